// file: hw/mpv_port_regs.sv
// writable alias bits of one copper port
`timescale 1ns/100ps
`default_nettype none
`include "mpv_params.svh"
module mpv_port_regs #(
  parameter bit HAS_FEF = 1'b1
) (
  input wire logic clk_sys_in,
  input wire logic sys_rst_in,
  input wire logic mii_ctl_we_in,
  input wire logic mii_adv_we_in,
  input wire logic [15:0] mii_wdata_in,
  input wire logic sw_an_we_in,
  input wire logic sw_ctl_we_in,
  input wire logic [7:0] sw_wdata_in,
  output logic an_enable_out,
  output logic [4:0] adv_out,
  output logic fef_disable_out,
  output logic tx_disable_out,
  output logic led_disable_out
);

  ////////////////////////////////////////////////////////////////////////////
  // advertisement bits: pause, 100f, 100h, 10f, 10h in switch bit order
  // management write wins when both paths write in the same cycle
  always_ff @(posedge clk_sys_in or posedge sys_rst_in)
  begin
    if (sys_rst_in)
    begin
      adv_out <= `MPV_ADV_RST;
    end
    else if (mii_adv_we_in)
    begin
      adv_out <= {mii_wdata_in[`MPV_ADV_PAUSE],
        mii_wdata_in[`MPV_ADV_SPEED_HI:`MPV_ADV_SPEED_LO]}; // RL11 RL12 RL13 RL14 RL15
    end
    else if (sw_an_we_in)
    begin
      adv_out <= sw_wdata_in[4:0]; // RL18
    end
  end

  // negotiation enable only reachable from the switch side here
  always_ff @(posedge clk_sys_in or posedge sys_rst_in)
  begin
    if (sys_rst_in)
    begin
      an_enable_out <= `MPV_AN_EN_RST;
    end
    else if (sw_an_we_in)
    begin
      an_enable_out <= sw_wdata_in[`MPV_SW_AN_EN]; // RL8
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // port control disables
  always_ff @(posedge clk_sys_in or posedge sys_rst_in)
  begin
    if (sys_rst_in)
    begin
      tx_disable_out <= `MPV_CTL_RST;
      led_disable_out <= `MPV_CTL_RST;
    end
    else if (mii_ctl_we_in)
    begin
      tx_disable_out <= mii_wdata_in[`MPV_CTL_TX_DIS]; // RL3
      led_disable_out <= mii_wdata_in[`MPV_CTL_LED_DIS]; // RL3
    end
    else if (sw_ctl_we_in)
    begin
      tx_disable_out <= sw_wdata_in[`MPV_SW_TX_DIS]; // RL18
      led_disable_out <= sw_wdata_in[`MPV_SW_LED_DIS]; // RL18
    end
  end

  // far-end fault disable exists on port 1 only, stuck at zero elsewhere
  always_ff @(posedge clk_sys_in or posedge sys_rst_in)
  begin
    if (sys_rst_in)
    begin
      fef_disable_out <= `MPV_CTL_RST;
    end
    else if (HAS_FEF && mii_ctl_we_in)
    begin
      fef_disable_out <= mii_wdata_in[`MPV_CTL_FEF_DIS]; // RL2
    end
    else if (HAS_FEF && sw_ctl_we_in)
    begin
      fef_disable_out <= sw_wdata_in[`MPV_SW_FEF_DIS]; // RL2
    end
  end

endmodule : mpv_port_regs
`default_nettype wire

// file: hw/mpv_register_view.sv
// phy management register view for the two copper ports
// Operation
// [RL1] phy address 1 selects port 1 registers, address 2 selects port 2
// [RL2] control bit 2 aliases far-end fault disable, port 1 only, reset 0
// [RL3] control bits 1 and 0 alias transmit and led disable, reset 0
// [RL4] status bits 14 to 11 always read one; writes ignored
// [RL5] status bits 15, 10 to 7 and 0 always read zero
// [RL6] status bits 5 and 2 mirror negotiation done and link up
// [RL7] status bit 4 mirrors the far-end fault flag
// [RL8] status bit 3 mirrors negotiation enable, reset one
// [RL9] register 2 returns fixed upper identifier word
// [RL10] register 3 returns fixed lower identifier word
// [RL11] advertise bit 10 pause, read/write, reset one, aliased
// [RL12] advertise bit 8, 100 full, read/write, reset one, aliased
// [RL13] advertise bit 7, 100 half, read/write, reset one, aliased
// [RL14] advertise bit 6, 10 full, read/write, reset one, aliased
// [RL15] advertise bit 5, 10 half, read/write, reset one, aliased
// [RL16] partner bit 10 mirrors partner pause capability, read only
// [RL17] selector reads 00001; next page, fault, acknowledge read zero
// [RL18] read-only writes ignored; alias writes seen on both paths at once
`timescale 1ns/100ps
`default_nettype none
`include "mpv_params.svh"
module mpv_register_view #(
  // identifier words; values are arbitrary
  parameter logic [15:0] ID_UPPER = 16'h5a00,
  parameter logic [15:0] ID_LOWER = 16'h00a5
) (
  input wire logic clk_sys_in,
  input wire logic sys_rst_in,
  input wire logic mgmt_req_in,
  input wire logic mgmt_write_in,
  input wire logic [4:0] phy_select_in,
  input wire logic [4:0] reg_select_in,
  input wire logic [15:0] mgmt_wdata_in,
  output logic mgmt_ack_out,
  output logic [15:0] mgmt_rdata_out,
  input wire logic sw_req_in,
  input wire logic sw_write_in,
  input wire logic [7:0] sw_addr_in,
  input wire logic [7:0] sw_wdata_in,
  output logic sw_ack_out,
  output logic [7:0] sw_rdata_out,
  input wire logic [1:0] negotiation_done_in,
  input wire logic [1:0] link_up_in,
  input wire logic [1:0] partner_pause_in,
  input wire logic far_end_fault_in,
  output logic [1:0] an_enable_out,
  output logic [9:0] adv_ability_out,
  output logic [1:0] tx_disable_out,
  output logic [1:0] led_disable_out,
  output logic fef_disable_out
);

  ////////////////////////////////////////////////////////////////////////////
  // address decoding shared by the read and write paths

  function automatic mpv_pkg::mpv_port_t phy_port(input logic [4:0] phy);
    case (phy)
      `MPV_PHY_PORT1: phy_port = mpv_pkg::MPV_PORT1; // RL1
      `MPV_PHY_PORT2: phy_port = mpv_pkg::MPV_PORT2; // RL1
      default: phy_port = mpv_pkg::MPV_PORT_NONE;
    endcase
  endfunction : phy_port

  function automatic mpv_pkg::mpv_port_t sw_port(input logic [7:0] addr);
    case (addr)
      `MPV_SW_P1_AN_CTL, `MPV_SW_P1_PORT_CTL,
      `MPV_SW_P1_PORT_STAT, `MPV_SW_P1_FAULT_STAT:
        sw_port = mpv_pkg::MPV_PORT1;
      `MPV_SW_P2_AN_CTL, `MPV_SW_P2_PORT_CTL,
      `MPV_SW_P2_PORT_STAT, `MPV_SW_P2_FAULT_STAT:
        sw_port = mpv_pkg::MPV_PORT2;
      default: sw_port = mpv_pkg::MPV_PORT_NONE;
    endcase
  endfunction : sw_port

  mpv_pkg::mpv_port_t mgmt_port;
  mpv_pkg::mpv_port_t sw_sel;
  logic mgmt_idx;
  logic sw_idx;
  logic [1:0] sw_sub;

  // offsets within a bank; both banks share the low two address bits
  localparam logic [7:0] SW_AN_CTL = `MPV_SW_P1_AN_CTL;
  localparam logic [7:0] SW_PORT_CTL = `MPV_SW_P1_PORT_CTL;

  // the two switch banks differ only in the upper nibble
  assign mgmt_port = phy_port(phy_select_in);
  assign sw_sel = sw_port(sw_addr_in);
  assign mgmt_idx = (mgmt_port == mpv_pkg::MPV_PORT2);
  assign sw_idx = (sw_sel == mpv_pkg::MPV_PORT2);
  assign sw_sub = sw_addr_in[1:0];

  ////////////////////////////////////////////////////////////////////////////
  // per-port alias storage and register word assembly

  mpv_pkg::mpv_word_t ctl_word [2];
  mpv_pkg::mpv_word_t stat_word [2];
  mpv_pkg::mpv_word_t adv_word [2];
  mpv_pkg::mpv_word_t lpa_word [2];
  mpv_pkg::mpv_byte_t sw_byte [2][4];
  logic [1:0] fef_dis;
  logic [1:0] fault;

  // only port 1 has a far-end fault flag
  assign fault = {1'b0, far_end_fault_in};
  assign fef_disable_out = fef_dis[0];

  genvar p;
  generate
    for (p = 0; p < 2; p++)
    begin : g_port
      localparam mpv_pkg::mpv_port_t SEL =
        (p == 0) ? mpv_pkg::MPV_PORT1 : mpv_pkg::MPV_PORT2;
      logic mii_ctl_we;
      logic mii_adv_we;
      logic sw_an_we;
      logic sw_ctl_we;
      logic [4:0] adv;

      // writes to status, identifier, partner or unknown addresses fall out
      assign mii_ctl_we = mgmt_req_in && mgmt_write_in && mgmt_port == SEL &&
        reg_select_in == `MPV_REG_CONTROL; // RL18
      assign mii_adv_we = mgmt_req_in && mgmt_write_in && mgmt_port == SEL &&
        reg_select_in == `MPV_REG_ADVERTISE; // RL18
      assign sw_an_we = sw_req_in && sw_write_in && sw_sel == SEL &&
        sw_sub == SW_AN_CTL[1:0]; // RL18
      assign sw_ctl_we = sw_req_in && sw_write_in && sw_sel == SEL &&
        sw_sub == SW_PORT_CTL[1:0]; // RL18

      mpv_port_regs #(
        .HAS_FEF(p == 0)
      ) u_regs (
        .clk_sys_in(clk_sys_in),
        .sys_rst_in(sys_rst_in),
        .mii_ctl_we_in(mii_ctl_we),
        .mii_adv_we_in(mii_adv_we),
        .mii_wdata_in(mgmt_wdata_in),
        .sw_an_we_in(sw_an_we),
        .sw_ctl_we_in(sw_ctl_we),
        .sw_wdata_in(sw_wdata_in),
        .an_enable_out(an_enable_out[p]),
        .adv_out(adv),
        .fef_disable_out(fef_dis[p]),
        .tx_disable_out(tx_disable_out[p]),
        .led_disable_out(led_disable_out[p])
      );

      assign adv_ability_out[5*p+4:5*p] = adv;

      // management-side words; unsupported bits are constant zero
      assign ctl_word[p] = {13'h0000, fef_dis[p], tx_disable_out[p],
        led_disable_out[p]}; // RL2 RL3
      assign stat_word[p] = {1'b0, `MPV_STAT_ABILITY, 4'h0, 1'b0,
        negotiation_done_in[p], fault[p], an_enable_out[p],
        link_up_in[p], 2'h0}; // RL4 RL5 RL6 RL7 RL8
      assign adv_word[p] = {5'h00, adv[4], 1'b0, adv[3:0],
        `MPV_ADV_SELECTOR}; // RL11 RL12 RL13 RL14 RL15 RL17
      assign lpa_word[p] = {5'h00, partner_pause_in[p], 10'h000}; // RL16 RL17

      // switch-side bytes for the same storage
      assign sw_byte[p][0] = {an_enable_out[p], 2'h0, adv};
      assign sw_byte[p][1] = {led_disable_out[p], tx_disable_out[p], 1'b0,
        fef_dis[p], 4'h0};
      assign sw_byte[p][2] = {1'b0, negotiation_done_in[p], link_up_in[p],
        partner_pause_in[p], 4'h0};
      assign sw_byte[p][3] = {7'h00, fault[p]};
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  // management read mux; an unmapped phy or register reads as zero

  mpv_pkg::mpv_word_t next_mgmt_rdata;

  always_comb
  begin
    next_mgmt_rdata = 16'h0000;
    if (mgmt_port != mpv_pkg::MPV_PORT_NONE)
    begin
      case (reg_select_in)
        `MPV_REG_CONTROL: next_mgmt_rdata = ctl_word[mgmt_idx];
        `MPV_REG_STATUS: next_mgmt_rdata = stat_word[mgmt_idx];
        `MPV_REG_ID_UPPER: next_mgmt_rdata = ID_UPPER; // RL9
        `MPV_REG_ID_LOWER: next_mgmt_rdata = ID_LOWER; // RL10
        `MPV_REG_ADVERTISE: next_mgmt_rdata = adv_word[mgmt_idx];
        `MPV_REG_PARTNER: next_mgmt_rdata = lpa_word[mgmt_idx];
        default: next_mgmt_rdata = 16'h0000;
      endcase
    end
  end

  // read data is registered, so it shows the state before a same-cycle write
  always_ff @(posedge clk_sys_in or posedge sys_rst_in)
  begin
    if (sys_rst_in)
    begin
      mgmt_ack_out <= 1'b0;
      mgmt_rdata_out <= 16'h0000;
    end
    else
    begin
      mgmt_ack_out <= mgmt_req_in;
      if (mgmt_req_in && !mgmt_write_in)
      begin
        mgmt_rdata_out <= next_mgmt_rdata;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // switch-side read port for the aliased switch registers

  always_ff @(posedge clk_sys_in or posedge sys_rst_in)
  begin
    if (sys_rst_in)
    begin
      sw_ack_out <= 1'b0;
      sw_rdata_out <= 8'h00;
    end
    else
    begin
      sw_ack_out <= sw_req_in;
      if (sw_req_in && !sw_write_in)
      begin
        sw_rdata_out <= (sw_sel == mpv_pkg::MPV_PORT_NONE) ? 8'h00 :
          sw_byte[sw_idx][sw_sub]; // RL18
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // checks

  logic last_read;
  logic last_hit;
  logic last_idx;
  logic [4:0] last_reg;

  // remember what the previous management read addressed
  always_ff @(posedge clk_sys_in or posedge sys_rst_in)
  begin
    if (sys_rst_in)
    begin
      last_read <= 1'b0;
      last_hit <= 1'b0;
      last_idx <= 1'b0;
      last_reg <= 5'h00;
    end
    else
    begin
      last_read <= mgmt_req_in && !mgmt_write_in;
      last_hit <= (mgmt_port != mpv_pkg::MPV_PORT_NONE);
      last_idx <= mgmt_idx;
      last_reg <= reg_select_in;
    end
  end

  default clocking cb @(posedge clk_sys_in);
  endclocking
  default disable iff (sys_rst_in);

  a_ack_one_cycle: assert property (mgmt_req_in |=> mgmt_ack_out) // RL1
    else $error("management ack missing");
  a_ack_drop: assert property (!mgmt_req_in |=> !mgmt_ack_out) // RL1
    else $error("management ack without request");
  a_sw_ack_one: assert property (sw_req_in |=> sw_ack_out) // RL18
    else $error("switch ack missing");
  a_unmapped_phy: assert property (last_read && !last_hit |-> // RL1
    mgmt_rdata_out == 16'h0000)
    else $error("unmapped phy read not zero");
  a_status_fixed: assert property (last_read && last_hit && // RL4 RL5
    last_reg == `MPV_REG_STATUS |-> mgmt_rdata_out[14:11] == 4'hf &&
    mgmt_rdata_out[15] == 1'b0 && mgmt_rdata_out[10:6] == 5'h00 &&
    mgmt_rdata_out[1:0] == 2'h0)
    else $error("status constant bits wrong");
  // mirrored bits are compared with their value at the read edge
  a_status_link: assert property (mgmt_req_in && !mgmt_write_in && // RL6
    reg_select_in == `MPV_REG_STATUS && mgmt_port != mpv_pkg::MPV_PORT_NONE
    |=> mgmt_rdata_out[2] == $past(link_up_in[mgmt_idx]) &&
    mgmt_rdata_out[5] == $past(negotiation_done_in[mgmt_idx]))
    else $error("status link or done not mirrored");
  a_status_able: assert property (mgmt_req_in && !mgmt_write_in && // RL8
    reg_select_in == `MPV_REG_STATUS && mgmt_port != mpv_pkg::MPV_PORT_NONE
    |=> mgmt_rdata_out[3] == $past(an_enable_out[mgmt_idx]))
    else $error("status negotiation ability not mirrored");
  a_fault_port1: assert property (mgmt_req_in && !mgmt_write_in && // RL7
    reg_select_in == `MPV_REG_STATUS && mgmt_port == mpv_pkg::MPV_PORT1
    |=> mgmt_rdata_out[4] == $past(far_end_fault_in))
    else $error("far-end fault not mirrored");
  a_id_words: assert property (last_read && last_hit && // RL9 RL10
    (last_reg == `MPV_REG_ID_UPPER || last_reg == `MPV_REG_ID_LOWER) |->
    mgmt_rdata_out == (last_reg == `MPV_REG_ID_UPPER ? ID_UPPER : ID_LOWER))
    else $error("identifier word wrong");
  a_adv_fixed: assert property (last_read && last_hit && // RL17
    last_reg == `MPV_REG_ADVERTISE |-> mgmt_rdata_out[4:0] == 5'h01 &&
    mgmt_rdata_out[15:11] == 5'h00 && mgmt_rdata_out[9] == 1'b0)
    else $error("advertisement fixed bits wrong");
  a_partner_fixed: assert property (last_read && last_hit && // RL16 RL17
    last_reg == `MPV_REG_PARTNER |-> mgmt_rdata_out[15:11] == 5'h00 &&
    mgmt_rdata_out[9:0] == 10'h000)
    else $error("partner fixed bits wrong");
  a_ctl_port2_fef: assert property (last_read && last_hit && // RL2
    last_idx && last_reg == `MPV_REG_CONTROL |->
    mgmt_rdata_out[15:2] == 14'h0000)
    else $error("port 2 control reads far-end fault disable");
  a_adv_write_alias: assert property (mgmt_req_in && mgmt_write_in && // RL11
    mgmt_port == mpv_pkg::MPV_PORT2 && reg_select_in == `MPV_REG_ADVERTISE
    |=> adv_ability_out[9:5] == {$past(mgmt_wdata_in[10]),
    $past(mgmt_wdata_in[8:5])})
    else $error("advertisement write not aliased");
  a_ctl_write_alias: assert property (mgmt_req_in && mgmt_write_in && // RL3
    mgmt_port == mpv_pkg::MPV_PORT1 && reg_select_in == `MPV_REG_CONTROL
    |=> fef_disable_out == $past(mgmt_wdata_in[2]) &&
    tx_disable_out[0] == $past(mgmt_wdata_in[1]) &&
    led_disable_out[0] == $past(mgmt_wdata_in[0]))
    else $error("control write not aliased");
  a_fef_port1_only: assert property (sw_req_in && sw_write_in && // RL2
    sw_addr_in == `MPV_SW_P2_PORT_CTL && !(mgmt_req_in && mgmt_write_in)
    |=> $stable(fef_disable_out))
    else $error("port 2 changed far-end fault disable");
  a_ro_write_ignored: assert property (mgmt_req_in && // RL18
    mgmt_write_in && reg_select_in == `MPV_REG_STATUS && !sw_req_in |=>
    $stable(adv_ability_out) && $stable(an_enable_out) &&
    $stable(tx_disable_out))
    else $error("read-only write changed state");
  a_sw_alias_seen: assert property (sw_req_in && sw_write_in && // RL18
    sw_addr_in == `MPV_SW_P1_AN_CTL && !(mgmt_req_in && mgmt_write_in)
    |=> adv_ability_out[4:0] == $past(sw_wdata_in[4:0]) &&
    an_enable_out[0] == $past(sw_wdata_in[7]))
    else $error("switch write not seen by alias");
  a_both_write_order: assert property (sw_req_in && sw_write_in && // RL18
    sw_addr_in == `MPV_SW_P1_AN_CTL && mgmt_req_in && mgmt_write_in &&
    mgmt_port == mpv_pkg::MPV_PORT1 && reg_select_in == `MPV_REG_ADVERTISE
    |=> adv_ability_out[4:0] == {$past(mgmt_wdata_in[10]),
    $past(mgmt_wdata_in[8:5])} && an_enable_out[0] == $past(sw_wdata_in[7]))
    else $error("management write did not win");
  a_reset_defaults: assert property ($fell(sys_rst_in) |-> // RL8
    an_enable_out == 2'h3 && adv_ability_out == 10'h3ff &&
    tx_disable_out == 2'h0)
    else $error("reset defaults wrong");

  c_status_read: cover property (last_read && last_reg == `MPV_REG_STATUS);
  c_adv_write: cover property (mgmt_req_in && mgmt_write_in &&
    reg_select_in == `MPV_REG_ADVERTISE);
  c_sw_ctl_write: cover property (sw_req_in && sw_write_in &&
    sw_sel != mpv_pkg::MPV_PORT_NONE);
  c_both_write: cover property (mgmt_req_in && mgmt_write_in &&
    sw_req_in && sw_write_in);
  c_partner_read: cover property (last_read && last_reg == `MPV_REG_PARTNER);

endmodule : mpv_register_view
`default_nettype wire

// file: shared/mpv_params.svh
// constants for the phy management register view
`ifndef MPV_PARAMS_SVH
`define MPV_PARAMS_SVH

// management phy addresses
`define MPV_PHY_PORT1 5'h01
`define MPV_PHY_PORT2 5'h02

// management register addresses
`define MPV_REG_CONTROL 5'h00
`define MPV_REG_STATUS 5'h01
`define MPV_REG_ID_UPPER 5'h02
`define MPV_REG_ID_LOWER 5'h03
`define MPV_REG_ADVERTISE 5'h04
`define MPV_REG_PARTNER 5'h05

// switch register addresses, port 1 and port 2 banks
`define MPV_SW_P1_AN_CTL 8'h1c
`define MPV_SW_P1_PORT_CTL 8'h1d
`define MPV_SW_P1_PORT_STAT 8'h1e
`define MPV_SW_P1_FAULT_STAT 8'h1f
`define MPV_SW_P2_AN_CTL 8'h2c
`define MPV_SW_P2_PORT_CTL 8'h2d
`define MPV_SW_P2_PORT_STAT 8'h2e
`define MPV_SW_P2_FAULT_STAT 8'h2f

// control register field positions
`define MPV_CTL_FEF_DIS 2
`define MPV_CTL_TX_DIS 1
`define MPV_CTL_LED_DIS 0

// status register field positions
`define MPV_STAT_AN_DONE 5
`define MPV_STAT_FAULT 4
`define MPV_STAT_AN_ABLE 3
`define MPV_STAT_LINK 2
`define MPV_STAT_ABILITY 4'hf

// advertisement and partner field positions
`define MPV_ADV_PAUSE 10
`define MPV_ADV_SPEED_HI 8
`define MPV_ADV_SPEED_LO 5
`define MPV_ADV_SELECTOR 5'h01

// switch register bit positions
`define MPV_SW_AN_EN 7
`define MPV_SW_FEF_DIS 4
`define MPV_SW_TX_DIS 6
`define MPV_SW_LED_DIS 7
`define MPV_SW_AN_DONE 6
`define MPV_SW_LINK 5
`define MPV_SW_LP_PAUSE 4
`define MPV_SW_FAULT 0

// reset values
`define MPV_ADV_RST 5'h1f
`define MPV_AN_EN_RST 1'b1
`define MPV_CTL_RST 1'b0

`endif

// file: shared/mpv_pkg.sv
// types for the phy management register view
package mpv_pkg;
  typedef logic [15:0] mpv_word_t;
  typedef logic [7:0] mpv_byte_t;
  typedef enum {MPV_PORT_NONE, MPV_PORT1, MPV_PORT2} mpv_port_t;
endpackage : mpv_pkg

// file: tb/mpv_register_view_test.sv
// self-checking bench for the phy management register view
`timescale 1ns/100ps
`default_nettype none
module mpv_register_view_test;
  localparam logic [15:0] ID_HI = 16'h3c0f; // arbitrary value
  localparam logic [15:0] ID_LO = 16'h0e71; // arbitrary value
  logic clk_sys_in, sys_rst_in, mgmt_req, mgmt_write, mgmt_ack;
  logic [4:0] phy_sel, reg_sel;
  logic [15:0] mgmt_wdata, mgmt_rdata;
  logic sw_req, sw_write, sw_ack, fault, fef_o, fef;
  logic [7:0] sw_addr, sw_wdata, sw_rdata;
  logic [1:0] neg_done, link_up, p_pause, an_en_o, tx_o, led_o;
  logic [1:0] an_en, tx, led;
  logic [9:0] adv_o;
  logic [4:0] adv [2];
  logic [31:0] seed, r;
  int error_cnt, n_compared, cycles;
  ////////////////////////////////////////////////////////////////////////
  mpv_register_view #(.ID_UPPER(ID_HI), .ID_LOWER(ID_LO))
  i_mpv_register_view (.clk_sys_in(clk_sys_in), .sys_rst_in(sys_rst_in),
    .mgmt_req_in(mgmt_req), .mgmt_write_in(mgmt_write),
    .phy_select_in(phy_sel), .reg_select_in(reg_sel),
    .mgmt_wdata_in(mgmt_wdata), .mgmt_ack_out(mgmt_ack),
    .mgmt_rdata_out(mgmt_rdata), .sw_req_in(sw_req),
    .sw_write_in(sw_write), .sw_addr_in(sw_addr), .sw_wdata_in(sw_wdata),
    .sw_ack_out(sw_ack), .sw_rdata_out(sw_rdata),
    .negotiation_done_in(neg_done), .link_up_in(link_up),
    .partner_pause_in(p_pause), .far_end_fault_in(fault),
    .an_enable_out(an_en_o), .adv_ability_out(adv_o),
    .tx_disable_out(tx_o), .led_disable_out(led_o),
    .fef_disable_out(fef_o));
  mpv_station_model i_mpv_station_model (.clk_sys_in(clk_sys_in),
    .mgmt_ack_in(mgmt_ack), .mgmt_rdata_in(mgmt_rdata),
    .mgmt_req_out(mgmt_req), .mgmt_write_out(mgmt_write),
    .phy_select_out(phy_sel), .reg_select_out(reg_sel),
    .mgmt_wdata_out(mgmt_wdata));
  ////////////////////////////////////////////////////////////////////////
  // free-running clock
  initial
  begin
    clk_sys_in = 1'b0;
    forever #5 clk_sys_in = ~clk_sys_in;
  end
  // repeatable random source
  function automatic logic [31:0] rnd();
    seed = {seed[30:0], ^(seed & 32'h80200003)};
    return seed;
  endfunction : rnd
  // expected management word from the shadow state and the live inputs
  function automatic logic [15:0] exp_mgmt(input logic [4:0] phy, rg);
    int p;
    p = (phy == 5'h02) ? 1 : 0;
    if (phy != 5'h01 && phy != 5'h02) return 16'h0000;
    case (rg)
      5'h00: return {13'h0000, (p == 0) & fef, tx[p], led[p]};
      5'h01: return {5'h0f, 5'h00, neg_done[p], (p == 0) & fault,
        an_en[p], link_up[p], 2'b00};
      5'h02: return ID_HI;
      5'h03: return ID_LO;
      5'h04: return {5'h00, adv[p][4], 1'b0, adv[p][3:0], 5'h01};
      5'h05: return {5'h00, p_pause[p], 10'h000};
      default: return 16'h0000;
    endcase
  endfunction : exp_mgmt
  // expected switch-side byte
  function automatic logic [7:0] exp_sw(input logic [7:0] a);
    int p;
    p = (a[7:4] == 4'h2) ? 1 : 0;
    if ((a[7:4] != 4'h1 && a[7:4] != 4'h2) || a[3:2] != 2'b11) return 8'h00;
    case (a[1:0])
      2'b00: return {an_en[p], 2'b00, adv[p]};
      2'b01: return {led[p], tx[p], 1'b0, (p == 0) & fef, 4'h0};
      2'b10: return {1'b0, neg_done[p], link_up[p], p_pause[p], 4'h0};
      default: return {7'h00, (p == 0) & fault};
    endcase
  endfunction : exp_sw
  task automatic shadow_reset();
    an_en = 2'b11;
    tx = 2'b00;
    led = 2'b00;
    fef = 1'b0;
    adv[0] = 5'h1f;
    adv[1] = 5'h1f;
  endtask : shadow_reset
  task automatic chk(input string what, input logic [15:0] ex, got);
    n_compared++;
    if (got !== ex)
    begin
      error_cnt++;
      $display("wrong value %s expected %h seen %h", what, ex, got);
    end
  endtask : chk
  ////////////////////////////////////////////////////////////////////////
  // one management access through the station model
  task automatic mgmt(input logic wr, input logic [4:0] phy, rg,
    input logic [15:0] wd);
    logic [15:0] rd, ex;
    logic ok;
    int p;
    ex = exp_mgmt(phy, rg);
    p = (phy == 5'h02) ? 1 : 0;
    i_mpv_station_model.xfer(wr, phy, rg, wd, rd, ok);
    chk("mgmt ack", 16'h0001, {15'h0000, ok});
    if (!wr) chk("mgmt rd", ex, rd);
    if (wr && (phy == 5'h01 || phy == 5'h02) && rg == 5'h00)
    begin
      tx[p] = wd[1];
      led[p] = wd[0];
      if (p == 0) fef = wd[2];
    end
    if (wr && (phy == 5'h01 || phy == 5'h02) && rg == 5'h04)
      adv[p] = {wd[10], wd[8:5]};
  endtask : mgmt
  // one switch-side access; request held for a following call
  task automatic swx(input logic wr, input logic [7:0] a, wd);
    logic [7:0] ex;
    int p;
    ex = exp_sw(a);
    p = (a[7:4] == 4'h2) ? 1 : 0;
    sw_req = 1'b1;
    sw_write = wr;
    sw_addr = a;
    sw_wdata = wd;
    @(negedge clk_sys_in);
    chk("sw ack", 16'h0001, {15'h0000, sw_ack});
    if (!wr) chk("sw rd", {8'h00, ex}, {8'h00, sw_rdata});
    if (wr && (a[7:4] == 4'h1 || a[7:4] == 4'h2) && a[3:2] == 2'b11)
    begin
      if (a[3:0] == 4'hc) {an_en[p], adv[p]} = {wd[7], wd[4:0]};
      if (a[3:0] == 4'hd) {led[p], tx[p]} = wd[7:6];
      if (a == 8'h1d) fef = wd[4];
    end
  endtask : swx
  task automatic sw_idle();
    sw_req = 1'b0;
    sw_addr = ~sw_addr;
    sw_wdata = ~sw_wdata;
    @(negedge clk_sys_in);
  endtask : sw_idle
  // alias outputs against the shadow
  task automatic chk_pins();
    chk("an_en", {14'h0000, an_en}, {14'h0000, an_en_o});
    chk("adv", {6'h00, adv[1], adv[0]}, {6'h00, adv_o});
    chk("tx_dis", {14'h0000, tx}, {14'h0000, tx_o});
    chk("led_dis", {14'h0000, led}, {14'h0000, led_o});
    chk("fef_dis", {15'h0000, fef}, {15'h0000, fef_o});
  endtask : chk_pins
  // read every place on both paths, unmapped ones included
  task automatic sweep();
    for (int ph = 0; ph < 4; ph++)
      for (int rg = 0; rg < 8; rg++)
        mgmt(1'b0, ph[4:0], rg[4:0], 16'h0000);
    i_mpv_station_model.idle();
    for (int h = 1; h < 4; h++)
      for (int l = 11; l < 16; l++)
        swx(1'b0, {h[3:0], l[3:0]}, 8'h00);
    sw_idle();
    chk_pins();
  endtask : sweep
  task automatic summarize();
    $display("compared %0d mismatches %0d", n_compared, error_cnt);
    if (error_cnt == 0 && n_compared > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask : summarize
  ////////////////////////////////////////////////////////////////////////
  // hang guard, well above the expected thousand or so cycles
  always @(posedge clk_sys_in)
  begin
    cycles <= cycles + 1;
    if (cycles == 20000)
    begin
      error_cnt++;
      summarize();
    end
  end
  // main sequence
  initial
  begin
    seed = 32'h00016907;
    error_cnt = 0;
    n_compared = 0;
    cycles = 0;
    sys_rst_in = 1'b1;
    {sw_req, sw_write, sw_addr, sw_wdata} = 18'h00000;
    {neg_done, link_up, p_pause, fault} = 7'h7f;
    shadow_reset();
    repeat (8) @(negedge clk_sys_in);
    sys_rst_in = 1'b0;
    sweep();
    $display("test reset defaults done");
    repeat (150)
    begin
      r = rnd();
      {neg_done, link_up, p_pause, fault} = r[6:0];
      if (r[13])
      begin
        mgmt(1'b1, {3'h0, r[9:8]}, {2'h0, r[12:10]}, r[31:16]);
        mgmt(1'b0, {3'h0, r[9:8]}, {2'h0, r[12:10]}, 16'h0000);
        i_mpv_station_model.idle();
      end
      else
      begin
        swx(1'b1, {2'b00, r[14], ~r[14], 2'b11, r[16:15]}, r[24:17]);
        sw_idle();
        mgmt(1'b0, {4'h0, r[14]} + 5'h01, 5'h00, 16'h0000);
        mgmt(1'b0, {4'h0, r[14]} + 5'h01, 5'h01, 16'h0000);
        mgmt(1'b0, {4'h0, r[14]} + 5'h01, 5'h04, 16'h0000);
        i_mpv_station_model.idle();
      end
      chk_pins();
    end
    // both paths write port 1 negotiation storage in one cycle
    fork
      mgmt(1'b1, 5'h01, 5'h04, 16'h0120);
      swx(1'b1, 8'h1c, 8'h1e);
    join
    adv[0] = 5'h09; // management write wins
    fork
      i_mpv_station_model.idle();
      sw_idle();
    join
    chk_pins();
    sweep();
    $display("test random aliasing done");
    sys_rst_in = 1'b1;
    repeat (2) @(negedge clk_sys_in);
    sys_rst_in = 1'b0;
    shadow_reset();
    sweep();
    $display("test mid-run reset done");
    summarize();
  end
endmodule : mpv_register_view_test
`default_nettype wire

// file: tb/mpv_station_model.sv
// behavioural station manager on the management request port
`timescale 1ns/100ps
`default_nettype none
module mpv_station_model (
  input wire logic clk_sys_in,
  input wire logic mgmt_ack_in,
  input wire logic [15:0] mgmt_rdata_in,
  output logic mgmt_req_out,
  output logic mgmt_write_out,
  output logic [4:0] phy_select_out,
  output logic [4:0] reg_select_out,
  output logic [15:0] mgmt_wdata_out
);
  // quiet bus at time zero
  initial
  begin
    mgmt_req_out = 1'b0;
    mgmt_write_out = 1'b0;
    phy_select_out = 5'h00;
    reg_select_out = 5'h00;
    mgmt_wdata_out = 16'h0000;
  end
  ////////////////////////////////////////////////////////////////////////
  // one access, entered just after a falling edge; the request stays up
  // so that a following call runs back to back
  task automatic xfer(input logic wr, input logic [4:0] phy,
    input logic [4:0] rg, input logic [15:0] wd,
    output logic [15:0] rd, output logic ok);
    mgmt_req_out = 1'b1;
    mgmt_write_out = wr;
    phy_select_out = phy;
    reg_select_out = rg;
    mgmt_wdata_out = wd;
    @(negedge clk_sys_in);
    ok = (mgmt_ack_in === 1'b1);
    rd = mgmt_rdata_in;
  endtask : xfer
  // released qualifiers stop showing the last value, so stale decode shows
  task automatic idle();
    mgmt_req_out = 1'b0;
    phy_select_out = ~phy_select_out;
    reg_select_out = ~reg_select_out;
    mgmt_wdata_out = ~mgmt_wdata_out;
    @(negedge clk_sys_in);
  endtask : idle
endmodule : mpv_station_model
`default_nettype wire
